// *** tams_cfg.svh ***
// constants of the trigger, arming and measurement block
// assumes a 100 MHz mclk; times are kept in microseconds
`ifndef TAMS_CFG_SVH
`define TAMS_CFG_SVH
`define TAMS_CLK_MHZ     100
`define TAMS_WIN50_US    20000
`define TAMS_WIN60_US    16600
`define TAMS_WIN100_US   10000
`define TAMS_SYNC_MAX_US 60000
`define TAMS_HZ50        16'h0032
`define TAMS_HZ60        16'h003C
`define TAMS_HZ100       16'h0064
`define TAMS_WTG_BIT     5
`define TAMS_ST_FAULT    5
`define TAMS_ST_PROT     4
`define TAMS_ST_MODE     3
`define TAMS_ST_ERRQ     2
`define TAMS_ST_LIST     1
`define TAMS_ST_OUT      0
`define TAMS_BOOT_CNT    2'h3
`endif

// *** tams_host.sv ***
// host-side model that issues parsed command tokens to the trigger block
// assumes one shared mclk; the bench calls send from its own sequence
`timescale 1ns/1ns
`default_nettype none
module tams_host import tams_pkg::*; (
   input  wire logic        mclk,
   output logic             cmd_valid,
   output logic [3:0]       cmd_code,
   output logic [15:0]      cmd_arg
);
   // --------------------------------
   // token driver
   // --------------------------------
   // quiet bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 4'h0;
      cmd_arg   = 16'h0000;
   end
   // one strobed token per call; code and argument are inverted once
   // released so a stale argument is never mistaken for a fresh one
   task automatic send(input tams_cmd_t c, input logic [15:0] a);
      @(posedge mclk);
      #1;
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_arg   = a;
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      cmd_code  = ~c;
      cmd_arg   = ~a;
   endtask : send
endmodule : tams_host
`default_nettype wire

// *** tams_pkg.sv ***
// types of the trigger, arming and measurement block
// shared by the top module and its verification
package tams_pkg;
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0, CMD_ABORT = 4'h1, CMD_INIT = 4'h2, CMD_CONT = 4'h3,
      CMD_TRG = 4'h4, CMD_RST = 4'h5, CMD_SRC = 4'h6, CMD_VTRIG = 4'h7,
      CMD_CTRIG = 4'h8, CMD_VOLT = 4'h9, CMD_CURR = 4'hA, CMD_MSYNC = 4'hB,
      CMD_MRATE = 4'hC, CMD_WENAB = 4'hD, CMD_QUERY = 4'hE, CMD_EVENT = 4'hF
   } tams_cmd_t;
   typedef enum logic [1:0] {Q_CONT = 2'h0, Q_SYNC = 2'h1, Q_RATE = 2'h2, Q_MEAS = 2'h3} tams_query_t;
   typedef enum logic [1:0] {R50 = 2'h0, R60 = 2'h1, R100 = 2'h2} tams_rate_t;
   typedef enum logic [1:0] {K_NUM = 2'h0, K_TOKEN = 2'h1, K_STAT = 2'h2} tams_kind_t;
   typedef enum logic {SRC_BUS = 1'b0, SRC_EXT = 1'b1} tams_src_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001, ST_VOLT = 4'b0010, ST_CURR = 4'b0100, ST_STAT = 4'b1000
   } tams_state_t;
endpackage : tams_pkg

// *** tams_top.sv ***
// trigger arming, waiting-for-trigger status and measurement control
// assumes parsed command tokens on mclk, one per cycle; analog values
// and status inputs come from logic on the same clock
`include "tams_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tams_top import tams_pkg::*; #(
   parameter int unsigned   WIN50_CYC    = `TAMS_WIN50_US * `TAMS_CLK_MHZ,
   parameter int unsigned   WIN60_CYC    = `TAMS_WIN60_US * `TAMS_CLK_MHZ,
   parameter int unsigned   WIN100_CYC   = `TAMS_WIN100_US * `TAMS_CLK_MHZ,
   parameter int unsigned   SYNC_MAX_CYC = `TAMS_SYNC_MAX_US * `TAMS_CLK_MHZ,
   parameter logic [7:0]    MEAS_EXP     = 8'hFD
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [15:0] cmd_arg,
   input  wire logic        ext_trig_pin,
   input  wire logic        disp_fast_pin,
   input  wire logic        fault_in,
   input  wire logic        prot_in,
   input  wire logic        cur_mode_in,
   input  wire logic        error_queue_nonempty,
   input  wire logic        list_run_in,
   input  wire logic        output_on_in,
   input  wire logic [15:0] meas_volt_in,
   input  wire logic [15:0] meas_curr_in,
   output logic [15:0]      volt_set,
   output logic [15:0]      curr_set,
   output logic             wtg,
   output logic             wtg_event,
   output logic             cont_arm,
   output logic             measure_sync_select,
   output logic [1:0]       measure_sample_rate,
   output logic             sample_tick,
   output logic [7:0]       measure_status_byte,
   output logic             reply_valid,
   output logic [1:0]       reply_kind,
   output logic [1:0]       reply_field,
   output logic [15:0]      reply_mant,
   output logic [7:0]       reply_exp,
   output logic             cmd_error
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [15:0] volt_set_r, curr_set_r, vtrig_r, ctrig_r, mvolt_r, mcurr_r;
   logic        armed_r, cont_r, wtg_r, wtg_event_r, wtg_enab_r, sync_r;
   logic        src_r, tick_r, rv_r, err_r, boot_done_r;
   logic [1:0]  rate_r, kind_r, field_r, boot_cnt_r;
   logic [15:0] mant_r;
   logic [7:0]  exp_r, status_r;
   logic [23:0] win_cnt_r;
   logic [2:0]  ext_s, disp_s;
   logic        ext_lvl_r;
   tams_state_t st_r;

   // counter reload for a rate code: the window length in cycles minus one
   function automatic logic [23:0] rate_cycles(input logic [1:0] r);
      rate_cycles = (r == R50) ? 24'(WIN50_CYC - 1) :
                    (r == R100) ? 24'(WIN100_CYC - 1) : 24'(WIN60_CYC - 1);
   endfunction : rate_cycles

   // ----------------------------------------------------------------
   // command decode
   // ----------------------------------------------------------------
   wire cmd_abort = cmd_valid && cmd_code == CMD_ABORT;
   wire cmd_init  = cmd_valid && cmd_code == CMD_INIT;
   wire cmd_cont  = cmd_valid && cmd_code == CMD_CONT;
   wire cmd_trg   = cmd_valid && cmd_code == CMD_TRG;
   wire cmd_rst   = cmd_valid && cmd_code == CMD_RST;
   wire cmd_src   = cmd_valid && cmd_code == CMD_SRC;
   wire cmd_vtrig = cmd_valid && cmd_code == CMD_VTRIG;
   wire cmd_ctrig = cmd_valid && cmd_code == CMD_CTRIG;
   wire cmd_volt  = cmd_valid && cmd_code == CMD_VOLT;
   wire cmd_curr  = cmd_valid && cmd_code == CMD_CURR;
   wire cmd_msync = cmd_valid && cmd_code == CMD_MSYNC;
   wire cmd_mrate = cmd_valid && cmd_code == CMD_MRATE;
   wire cmd_wenab = cmd_valid && cmd_code == CMD_WENAB;
   wire cmd_query = cmd_valid && cmd_code == CMD_QUERY;
   wire cmd_event = cmd_valid && cmd_code == CMD_EVENT;
   wire st_idle   = st_r == ST_IDLE;
   // a query while a measure reply is still streaming would collide
   wire q_refuse  = (cmd_query || cmd_event) && !st_idle;
   wire q_take    = cmd_query && st_idle;
   wire q_meas    = q_take && cmd_arg[1:0] == Q_MEAS;

   // legal rate arguments only; anything else is refused
   wire rate_is50  = cmd_arg == `TAMS_HZ50;
   wire rate_is60  = cmd_arg == `TAMS_HZ60;
   wire rate_is100 = cmd_arg == `TAMS_HZ100;
   wire rate_ok    = rate_is50 || rate_is60 || rate_is100;
   wire [1:0] rate_arg = rate_is50 ? R50 : (rate_is100 ? R100 : R60);
   wire rate_bad   = cmd_mrate && !rate_ok;

   // ----------------------------------------------------------------
   // external trigger and strap synchronisers
   // ----------------------------------------------------------------
   // level moves only when stages two and three agree
   wire ext_agree = ext_s[1] == ext_s[2];
   wire ext_rise  = ext_agree && ext_s[2] && !ext_lvl_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ext_s     <= 3'h0;
         disp_s    <= 3'h0;
         ext_lvl_r <= 1'b0;
      end else begin
         ext_s     <= {ext_s[1:0], ext_trig_pin};
         disp_s    <= {disp_s[1:0], disp_fast_pin};
         ext_lvl_r <= ext_agree ? ext_s[2] : ext_lvl_r;
      end
   end

   // ----------------------------------------------------------------
   // trigger arming and waiting-for-trigger
   // ----------------------------------------------------------------
   wire trg_req = (cmd_trg && src_r == SRC_BUS) || (ext_rise && src_r == SRC_EXT);
   wire fire    = trg_req && (armed_r || cont_r);
   wire armed_nxt = cmd_rst ? 1'b0 :
                    (cmd_abort && !cont_r) ? 1'b0 :
                    (cmd_init && !cont_r) ? 1'b1 :
                    (fire && !cont_r) ? 1'b0 : armed_r;
   wire cont_nxt = cmd_rst ? 1'b0 : (cmd_cont ? cmd_arg[0] : cont_r);
   // continuous: bus reads solid 1, external dips for one cycle per trigger
   wire wtg_nxt = cmd_rst ? 1'b0 :
                  cont_r ? ((src_r == SRC_BUS) ? 1'b1 : !fire) :
                  armed_nxt;
   wire wtg_chg = wtg_nxt != wtg_r && wtg_enab_r && src_r == SRC_EXT;
   wire setpt_chg = cmd_volt || cmd_curr || fire;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         armed_r <= 1'b0;
         cont_r  <= 1'b0;
         wtg_r   <= 1'b0;
         src_r   <= SRC_BUS;
      end else begin
         armed_r <= armed_nxt;
         cont_r  <= cont_nxt;
         wtg_r   <= wtg_nxt;
         src_r   <= cmd_src ? cmd_arg[0] : src_r;
      end
   end

   // event bit is read-and-clear; a new transition wins over the clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wtg_event_r <= 1'b0;
         wtg_enab_r  <= 1'b0;
      end else begin
         wtg_event_r <= wtg_chg || (wtg_event_r && !(cmd_event && st_idle));
         wtg_enab_r  <= cmd_wenab ? cmd_arg[`TAMS_WTG_BIT] : wtg_enab_r;
      end
   end

   // setpoints; an accepted trigger applies the triggered values
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         volt_set_r <= 16'h0000;
         curr_set_r <= 16'h0000;
         vtrig_r    <= 16'h0000;
         ctrig_r    <= 16'h0000;
      end else begin
         volt_set_r <= fire ? vtrig_r : (cmd_volt ? cmd_arg : volt_set_r);
         curr_set_r <= fire ? ctrig_r : (cmd_curr ? cmd_arg : curr_set_r);
         vtrig_r    <= cmd_vtrig ? cmd_arg : vtrig_r;
         ctrig_r    <= cmd_ctrig ? cmd_arg : ctrig_r;
      end
   end

   // ----------------------------------------------------------------
   // measurement timing
   // ----------------------------------------------------------------
   // the strap is read only once its synchroniser has filled
   wire boot_take = !boot_done_r && boot_cnt_r == `TAMS_BOOT_CNT;
   wire win_zero  = win_cnt_r == 24'h000000;
   // sync mode restarts the window on a setpoint change, so a fresh
   // sample lands within one window; free-running mode does not restart on a setpoint change
   wire win_load  = win_zero || (sync_r && setpt_chg) || (cmd_mrate && rate_ok) || boot_take;
   wire [1:0] rate_nxt = boot_take ? (disp_s[2] ? R100 : R60) :
                         (cmd_mrate && rate_ok) ? rate_arg : rate_r;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         boot_cnt_r  <= 2'h0;
         boot_done_r <= 1'b0;
         rate_r      <= R60;
         sync_r      <= 1'b0;
         win_cnt_r   <= 24'h000000;
         tick_r      <= 1'b0;
      end else begin
         boot_cnt_r  <= boot_done_r ? boot_cnt_r : boot_cnt_r + 2'h1;
         boot_done_r <= boot_done_r || boot_take;
         rate_r      <= rate_nxt;
         sync_r      <= cmd_msync ? cmd_arg[0] : sync_r;
         win_cnt_r   <= win_load ? rate_cycles(rate_nxt) : win_cnt_r - 24'h000001;
         tick_r      <= win_zero;
      end
   end

   // samples are captured on the window end; status is registered every cycle
   wire [7:0] stat_w;
   assign stat_w[7:6]            = 2'h0;
   assign stat_w[`TAMS_ST_FAULT] = fault_in;
   assign stat_w[`TAMS_ST_PROT]  = prot_in;
   assign stat_w[`TAMS_ST_MODE]  = cur_mode_in;
   assign stat_w[`TAMS_ST_ERRQ]  = error_queue_nonempty;
   assign stat_w[`TAMS_ST_LIST]  = list_run_in;
   assign stat_w[`TAMS_ST_OUT]   = output_on_in;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         mvolt_r  <= 16'h0000;
         mcurr_r  <= 16'h0000;
         status_r <= 8'h00;
      end else begin
         mvolt_r  <= win_zero ? meas_volt_in : mvolt_r;
         mcurr_r  <= win_zero ? meas_curr_in : mcurr_r;
         status_r <= stat_w;
      end
   end

   // ----------------------------------------------------------------
   // replies
   // ----------------------------------------------------------------
   wire [15:0] rate_mant = (rate_r == R100) ? 16'h0001 : ((rate_r == R50) ? 16'h0005 : 16'h0006);
   wire [7:0]  rate_exp  = (rate_r == R100) ? 8'h02 : 8'h01;
   wire [1:0]  qsel      = cmd_arg[1:0];
   // simple replies go out the cycle after the query
   wire        rv_nxt    = (q_take && qsel != Q_MEAS) || (cmd_event && st_idle) || !st_idle;
   wire [1:0]  kind_nxt  = (st_r == ST_STAT) ? K_STAT :
                           (q_take && qsel == Q_SYNC) ? K_TOKEN : K_NUM;
   wire [1:0]  field_nxt = (st_r == ST_CURR) ? 2'h1 : ((st_r == ST_STAT) ? 2'h2 : 2'h0);
   wire [15:0] mant_nxt  = (st_r == ST_VOLT) ? mvolt_r :
                           (st_r == ST_CURR) ? mcurr_r :
                           (st_r == ST_STAT) ? {8'h00, status_r} :
                           cmd_event ? {15'h0000, wtg_event_r} :
                           (qsel == Q_CONT) ? {15'h0000, cont_r} :
                           (qsel == Q_SYNC) ? {15'h0000, sync_r} :
                           rate_mant;
   wire [7:0]  exp_nxt   = (st_r == ST_VOLT || st_r == ST_CURR) ? MEAS_EXP :
                           (q_take && qsel == Q_RATE) ? rate_exp : 8'h00;

   // the measure reply walks voltage, current, status
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= ST_IDLE;
      end else begin
         unique case (st_r)
            ST_IDLE: st_r <= q_meas ? ST_VOLT : ST_IDLE;
            ST_VOLT: st_r <= ST_CURR;
            ST_CURR: st_r <= ST_STAT;
            ST_STAT: st_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rv_r    <= 1'b0;
         kind_r  <= K_NUM;
         field_r <= 2'h0;
         mant_r  <= 16'h0000;
         exp_r   <= 8'h00;
         err_r   <= 1'b0;
      end else begin
         rv_r    <= rv_nxt;
         kind_r  <= kind_nxt;
         field_r <= field_nxt;
         mant_r  <= mant_nxt;
         exp_r   <= exp_nxt;
         err_r   <= q_refuse || rate_bad;
      end
   end

   assign volt_set            = volt_set_r;
   assign curr_set            = curr_set_r;
   assign wtg                 = wtg_r;
   assign wtg_event           = wtg_event_r;
   assign cont_arm            = cont_r;
   assign measure_sync_select = sync_r;
   assign measure_sample_rate = rate_r;
   assign sample_tick         = tick_r;
   assign measure_status_byte = status_r;
   assign reply_valid         = rv_r;
   assign reply_kind          = kind_r;
   assign reply_field         = field_r;
   assign reply_mant          = mant_r;
   assign reply_exp           = exp_r;
   assign cmd_error           = err_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   // cycles since a setpoint change in sync mode without a fresh sample
   logic [23:0] since_r;
   always_ff @(posedge mclk) begin
      if (!rst_n || !sync_r || win_zero) since_r <= 24'h000000;
      else if (setpt_chg || since_r != 24'h000000) since_r <= since_r + 24'h000001;
   end

   property p_abort_single;
      @(posedge mclk) disable iff (!rst_n) cmd_abort && !cont_r |=> !armed_r && !wtg_r;
   endproperty
   a_abort_single: assert property (p_abort_single) else $error("abort left arming");
   property p_abort_cont;
      @(posedge mclk) disable iff (!rst_n) cmd_abort && cont_r && !fire |=> $stable(armed_r) && $stable(wtg_r);
   endproperty
   a_abort_cont: assert property (p_abort_cont) else $error("abort acted in continuous");
   property p_src_gate;
      @(posedge mclk) disable iff (!rst_n) cmd_trg && src_r == SRC_EXT && !ext_rise |=> $stable(volt_set_r);
   endproperty
   a_src_gate: assert property (p_src_gate) else $error("bus trigger taken off bus source");
   property p_load;
      @(posedge mclk) disable iff (!rst_n) fire |=> volt_set_r == $past(vtrig_r) && curr_set_r == $past(ctrig_r);
   endproperty
   a_load: assert property (p_load) else $error("triggered values not applied");
   property p_consume;
      @(posedge mclk) disable iff (!rst_n) cmd_trg && !armed_r && !cont_r |=> $stable(volt_set_r) && $stable(curr_set_r);
   endproperty
   a_consume: assert property (p_consume) else $error("second trigger accepted");
   property p_cont_bus;
      @(posedge mclk) disable iff (!rst_n) cont_r && src_r == SRC_BUS && !cmd_rst && !cmd_cont && !cmd_src |=> wtg_r;
   endproperty
   a_cont_bus: assert property (p_cont_bus) else $error("waiting flag not 1");
   property p_cont_ext;
      @(posedge mclk) disable iff (!rst_n) cont_r && src_r == SRC_EXT && fire && !cmd_rst |=> !wtg_r;
   endproperty
   a_cont_ext: assert property (p_cont_ext) else $error("waiting flag did not drop");
   property p_event;
      @(posedge mclk) disable iff (!rst_n) wtg_chg |=> wtg_event_r;
   endproperty
   a_event: assert property (p_event) else $error("transition not latched");
   property p_rst;
      @(posedge mclk) disable iff (!rst_n) cmd_rst |=> !cont_r && !wtg_r;
   endproperty
   a_rst: assert property (p_rst) else $error("reset command missed");
   property p_meas;
      @(posedge mclk) disable iff (!rst_n)
         q_meas |=> ##1 (rv_r && field_r == 2'h0) ##1 (rv_r && field_r == 2'h1) ##1 (rv_r && kind_r == K_STAT);
   endproperty
   a_meas: assert property (p_meas) else $error("measure reply order");
   property p_stat;
      @(posedge mclk) disable iff (!rst_n) 1'b1 |=> status_r[7:6] == 2'h0 && status_r[3] == $past(cur_mode_in);
   endproperty
   a_stat: assert property (p_stat) else $error("status byte layout");
   property p_sync;
      @(posedge mclk) disable iff (!rst_n) since_r <= 24'(SYNC_MAX_CYC);
   endproperty
   a_sync: assert property (p_sync) else $error("sync update late");
   // the bound above holds in either mode, so also check the restart itself
   property p_sync_restart;
      @(posedge mclk) disable iff (!rst_n) sync_r && setpt_chg |=> win_cnt_r == rate_cycles(rate_r);
   endproperty
   a_sync_restart: assert property (p_sync_restart) else $error("sync window not restarted");
   property p_rate;
      @(posedge mclk) disable iff (!rst_n) rate_r == R50 || rate_r == R60 || rate_r == R100;
   endproperty
   a_rate: assert property (p_rate) else $error("illegal rate");

   property p_cv_bus;
      @(posedge mclk) disable iff (!rst_n) fire && src_r == SRC_BUS;
   endproperty
   c_cv_bus: cover property (p_cv_bus);
   property p_cv_ext;
      @(posedge mclk) disable iff (!rst_n) fire && cont_r && src_r == SRC_EXT ##1 !wtg_r ##1 wtg_r;
   endproperty
   c_cv_ext: cover property (p_cv_ext);
   property p_cv_meas;
      @(posedge mclk) disable iff (!rst_n) rv_r && kind_r == K_STAT;
   endproperty
   c_cv_meas: cover property (p_cv_meas);
endmodule : tams_top
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the trigger, arming and measure block
// assumes shortened sample windows; the host model sends all tokens
`timescale 1ns/1ns
`default_nettype none
module tb_top import tams_pkg::*; ;
   // --------------------------------
   // signals and instances
   // --------------------------------
   logic        mclk, rst_n, cmd_valid, ext_trig_pin, disp_fast, wtg, wtg_event, cont_arm, measure_sync_select;
   logic        sample_tick, reply_valid, cmd_error;
   logic [1:0]  measure_sample_rate, r_kind, r_field, rk, rf;
   logic [3:0]  cmd_code;
   logic [5:0]  st_in;
   logic [7:0]  stat, r_exp, re;
   logic [15:0] cmd_arg, mv, mc, volt_set, curr_set, r_mant, rm;
   logic [15:0] hz [3] = '{16'h0032, 16'h003C, 16'h0064};
   int          win [3] = '{20, 17, 10};
   int          fails, check_count, cycles, i, n;
   tams_host u_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg));
   tams_top #(.WIN50_CYC(20), .WIN60_CYC(17), .WIN100_CYC(10), .SYNC_MAX_CYC(60)) u_dut (
      .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
      .ext_trig_pin(ext_trig_pin), .disp_fast_pin(disp_fast), .fault_in(st_in[5]), .prot_in(st_in[4]),
      .cur_mode_in(st_in[3]), .error_queue_nonempty(st_in[2]), .list_run_in(st_in[1]),
      .output_on_in(st_in[0]), .meas_volt_in(mv), .meas_curr_in(mc), .volt_set(volt_set),
      .curr_set(curr_set), .wtg(wtg), .wtg_event(wtg_event), .cont_arm(cont_arm),
      .measure_sync_select(measure_sync_select), .measure_sample_rate(measure_sample_rate),
      .sample_tick(sample_tick), .measure_status_byte(stat), .reply_valid(reply_valid),
      .reply_kind(r_kind), .reply_field(r_field), .reply_mant(r_mant), .reply_exp(r_exp),
      .cmd_error(cmd_error));
   // --------------------------------
   // helpers
   // --------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic cmd(input tams_cmd_t c, input logic [15:0] a);
      u_host.send(c, a);
   endtask : cmd
   // bounded wait for one reply field; a missing field leaves the mantissa unknown
   task automatic reply();
      for (int j = 0; j < 8 && reply_valid !== 1'b1; j++) cyc(1);
      rm = (reply_valid === 1'b1) ? r_mant : 16'hXXXX;
      {rk, rf, re} = {r_kind, r_field, r_exp};
      cyc(1);
   endtask : reply
   task automatic wait_tick(output int k);
      for (k = 1; k < 200 && sample_tick !== 1'b1; k++) cyc(1);
   endtask : wait_tick
   // scales a mantissa by its decimal exponent
   function automatic logic [15:0] val(input logic [15:0] m, input logic [7:0] e);
      val = m;
      if (e[7]) repeat (-$signed(e)) val = val / 10;
      else repeat (e) val = val * 10;
   endfunction : val
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   // --------------------------------
   // clock, watchdog and sequence
   // --------------------------------
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // the run needs under a thousand cycles, so this only catches a hang
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         complete_run();
      end
   end
   initial begin
      {rst_n, ext_trig_pin, disp_fast, st_in, mv, mc} = '0;
      cyc(2);
      rst_n = 1'b1;
      cyc(6);
      chk(measure_sample_rate, 16'h0001);
      chk({cont_arm, measure_sync_select, wtg}, 16'h0000);
      cmd(CMD_SRC, 16'h0000);
      cmd(CMD_VTRIG, 16'h0F00);
      cmd(CMD_CTRIG, 16'h0300);
      cmd(CMD_VOLT, 16'h2100);
      cmd(CMD_INIT, 16'h0000);
      chk(wtg, 16'h0001);
      cmd(CMD_TRG, 16'h0000);
      chk({volt_set, curr_set}, 32'h0F000300);
      chk(wtg, 32'h00000000);
      cmd(CMD_VOLT, 16'h2100);
      cmd(CMD_TRG, 16'h0000);
      chk(volt_set, 16'h2100);
      cmd(CMD_INIT, 16'h0000);
      cmd(CMD_ABORT, 16'h0000);
      cmd(CMD_TRG, 16'h0000);
      chk({volt_set, wtg}, {16'h2100, 1'b0});
      cmd(CMD_CONT, 16'h0001);
      cmd(CMD_QUERY, 16'h0000);
      reply();
      chk(rm, 16'h0001);
      cmd(CMD_ABORT, 16'h0000);
      chk({cont_arm, wtg}, 16'h0003);
      for (i = 0; i < 2; i++) begin
         cmd(CMD_VOLT, 16'h2100);
         cmd(CMD_TRG, 16'h0000);
         chk(volt_set, 16'h0F00);
      end
      // external source: bus tokens ignored, rising pin edges fire and pulse the flag
      cmd(CMD_WENAB, 16'h0020);
      cmd(CMD_SRC, 16'h0001);
      cmd(CMD_VOLT, 16'h2100);
      cmd(CMD_TRG, 16'h0000);
      chk({volt_set, wtg_event}, {16'h2100, 1'b0});
      ext_trig_pin = 1'b1;
      for (i = 0; i < 10 && wtg !== 1'b0; i++) cyc(1);
      chk({volt_set, wtg}, {16'h0F00, 1'b0});
      cyc(1);
      chk(wtg, 16'h0001);
      cyc(1);
      chk(wtg_event, 16'h0001);
      // the event bit reads back once, then reads clear
      cmd(CMD_EVENT, 16'h0000);
      reply();
      chk(rm, 16'h0001);
      cmd(CMD_EVENT, 16'h0000);
      reply();
      chk(rm, 16'h0000);
      ext_trig_pin = 1'b0;
      cmd(CMD_RST, 16'h0000);
      chk({cont_arm, wtg}, 16'h0000);
      cmd(CMD_QUERY, 16'h0000);
      reply();
      chk(rm, 16'h0000);
      for (i = 0; i < 3; i++) begin
         cmd(CMD_MRATE, hz[i]);
         chk(measure_sample_rate, 16'(i));
         cmd(CMD_QUERY, 16'h0002);
         reply();
         chk(val(rm, re), hz[i]);
         wait_tick(n);
         cyc(1);
         wait_tick(n);
         chk(16'(n), 16'(win[i]));
      end
      cmd(CMD_MRATE, 16'h0037);
      chk({measure_sample_rate, cmd_error}, 16'h0005);
      {st_in, mv, mc} = {6'h2D, 16'h1234, 16'h0567};
      wait_tick(n);
      cyc(1);
      cmd(CMD_QUERY, 16'h0003);
      reply();
      chk({rf, re, rm}, {2'h0, 8'hFD, 16'h1234});
      reply();
      chk({rf, rm}, {2'h1, 16'h0567});
      reply();
      chk({rk, rf, rm[7:0]}, {2'h2, 2'h2, 8'h2D});
      st_in = 6'h12;
      cyc(2);
      chk(stat, 16'h0012);
      cmd(CMD_QUERY, 16'h0003);
      cmd(CMD_QUERY, 16'h0000);
      chk(cmd_error, 16'h0001);
      cyc(4);
      cmd(CMD_MSYNC, 16'h0001);
      cmd(CMD_QUERY, 16'h0001);
      reply();
      chk({measure_sync_select, rk, rm}, {1'b1, 2'h1, 16'h0001});
      // a restarted window puts the next tick exactly one window after the change
      cmd(CMD_VOLT, 16'h0100);
      cyc(1);
      wait_tick(n);
      chk(n, win[2]);
      cmd(CMD_MSYNC, 16'h0000);
      cmd(CMD_QUERY, 16'h0001);
      reply();
      chk(rm, 16'h0000);
      // second reset in mid-run with the strap high selects the fast rate
      rst_n = 1'b0;
      disp_fast = 1'b1;
      cyc(2);
      rst_n = 1'b1;
      cyc(6);
      chk(measure_sample_rate, 32'h00000002);
      chk({cont_arm, measure_sync_select, wtg}, 32'h00000000);
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
